// File: dv/p0pfc_chk.sv
/* Checker for the pin control block.
 Bound to p0pfc_top; sees its ports only. */
`timescale 1ns/1ps
module p0pfc_chk (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic       sfr_we_i,
	input wire logic       sfr_re_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       sfr_hit_o,
	input wire logic [7:0] p0_pin_oe_o,
	input wire logic [7:0] p0_din_en_o,
	input wire logic [7:0] p0_half_bias_o,
	input wire logic [7:0] p0_analog_o,
	input wire logic [1:0] led_duty_select_o,
	input wire logic [3:0] led_seg_count_o,
	input wire logic       serial_port_on_o,
	input wire logic       spi_select_pin_o,
	input wire logic [3:0] converter_channel_select_i,
	input wire logic       bandgap_route_on_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire [7:0] ovr = p0_half_bias_o | p0_analog_o;
	property p_ovr; (p0_pin_oe_o & ovr) == 8'h00; endproperty
	a_ovr: assert property (p_ovr) else $error("drive on override");
	property p_din; p0_din_en_o == ~(p0_pin_oe_o | ovr); endproperty
	a_din: assert property (p_din) else $error("input enable");
	property p_ain;
		sfr_we_i && sfr_addr_i == 8'haf |=>
			p0_analog_o == {$past(sfr_wdata_i[7:4]), 4'h0};
	endproperty
	a_ain: assert property (p_ain) else $error("analog low");
	property p_wr;
		sfr_we_i && sfr_addr_i == 8'h91 |=>
			p0_pin_oe_o == ($past(sfr_wdata_i) & ~ovr);
	endproperty
	a_wr: assert property (p_wr) else $error("drive write");
	property p_rd; sfr_re_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00; endproperty
	a_rd: assert property (p_rd) else $error("unmapped read");
	property p_spi; spi_select_pin_o |-> serial_port_on_o; endproperty
	a_spi: assert property (p_spi) else $error("select pin");
	property p_led;
		led_seg_count_o == (led_duty_select_o == 2'h0 ? 4'h0 :
			4'(led_duty_select_o) + 4'h3);
	endproperty
	a_led: assert property (p_led) else $error("led segments");
	property p_bg; bandgap_route_on_o |-> converter_channel_select_i == 4'hb;
	endproperty
	a_bg: assert property (p_bg) else $error("bandgap route");
	c_wr: cover property (sfr_we_i && sfr_addr_i == 8'h92);
	c_bg: cover property (bandgap_route_on_o);
	c_led: cover property (led_seg_count_o == 4'h6);
endmodule
bind p0pfc_top p0pfc_chk p0pfc_chk_inst (.*);

// File: dv/p0pfc_pad.sv
/* Pad model for Port0 pins.
 Assumes drive, enable and pull-up from the pin control block. */
`timescale 1ns/1ps
module p0pfc_pad (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] oe_i,
	input  wire logic [7:0] dout_i,
	input  wire logic [7:0] pu_i,
	output logic      [7:0] pin_o
);
	logic [7:0] tog_ff;
	// Floating pins toggle every cycle
	always_ff @(posedge clk_i)
		tog_ff <= rst_i ? 8'h55 : ~tog_ff;
	assign pin_o = (oe_i & dout_i) | (~oe_i & (pu_i | tog_ff));
endmodule

// File: dv/tb_top.sv
/* Testbench for the pin control block.
 Assumes the SFR strobe protocol and pad model. */
`timescale 1ns/1ps
module tb_top;
	logic       clk_i, rst_i, sfr_we_i, sfr_re_i, sfr_hit_o;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, p0_pin_i, p0_pin_o;
	logic [7:0] p0_pin_oe_o, p0_pullup_o, p0_din_en_o, p0_half_bias_o;
	logic [7:0] p0_analog_o, p0_in_sync_o, p1_half_bias_o, p3_half_bias_o;
	logic [1:0] p2_half_bias_o, led_duty_select_o;
	logic [3:0] led_seg_count_o, converter_channel_select_i;
	logic       led_pins_auto_o, serial_port_on_o, spi_select_pin_o;
	logic       bandgap_route_on_o;
	int         err_count, total_checks;
	logic [7:0] ad[10] = '{8'h80, 8'h91, 8'h92, 8'haf, 8'hb1,
		8'hbc, 8'hd1, 8'hd2, 8'hd3, 8'hf7};
	logic [7:0] rv[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h06};
	logic [7:0] mk[10] = '{8'hff, 8'hff, 8'hff, 8'hf0, 8'hff,
		8'hff, 8'hff, 8'h03, 8'hff, 8'hf7};
	p0pfc_top p0pfc_top_inst (.*);
	p0pfc_pad p0pfc_pad_inst (.clk_i, .rst_i, .oe_i(p0_pin_oe_o),
		.dout_i(p0_pin_o), .pu_i(p0_pullup_o), .pin_o(p0_pin_i));
	////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [7:0] g, logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_i);
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_we_i <= 1'b1;
		@(posedge clk_i);
		sfr_we_i <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk_i);
		sfr_addr_i <= a;
		sfr_re_i <= 1'b1;
		@(posedge clk_i);
		sfr_re_i <= 1'b0;
		@(posedge clk_i);
		#1 chk("rdata", sfr_rdata_o, e);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (5000) @(posedge clk_i);
		err_count++;
		results();
	end
	initial
	begin
		{rst_i, sfr_we_i, sfr_re_i} = 3'h4;
		{sfr_addr_i, sfr_wdata_i} = 16'h0000;
		converter_channel_select_i = 4'ha;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ad[i]) rd(ad[i], rv[i]);
		chk("hit1", 8'(sfr_hit_o), 8'h01);
		rd(8'h81, 8'h00);
		chk("hit", 8'(sfr_hit_o), 8'h00);
		wr(8'h80, 8'ha5);
		chk("pullup", p0_pullup_o, 8'ha5);
		chk("din", p0_din_en_o, 8'hff);
		wr(8'h91, 8'h0f);
		chk("oe", p0_pin_oe_o, 8'h0f);
		chk("pullup2", p0_pullup_o, 8'ha0);
		chk("dout", p0_pin_o, 8'h05);
		repeat (4) @(posedge clk_i);
		#1 chk("sync", p0_in_sync_o & 8'h0f, 8'h05);
		wr(8'h92, 8'h01);
		wr(8'haf, 8'h8f);
		chk("oe3", p0_pin_oe_o, 8'h0e);
		chk("din3", p0_din_en_o, 8'h70);
		chk("ain", p0_analog_o, 8'h80);
		chk("hb", p0_half_bias_o, 8'h01);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'hb1, 8'(i << 6) | 8'h04);
			chk("duty", 8'(led_duty_select_o), 8'(i));
			chk("seg", 8'(led_seg_count_o), 8'(i ? i + 3 : 0));
			chk("auto", 8'(led_pins_auto_o), 8'(i != 0));
		end
		wr(8'hbc, 8'h80);
		chk("spi", 8'({serial_port_on_o, spi_select_pin_o}), 8'h03);
		wr(8'hbc, 8'h88);
		chk("ss", 8'(spi_select_pin_o), 8'h00);
		wr(8'hf7, 8'h16);
		chk("bg0", 8'(bandgap_route_on_o), 8'h00);
		@(posedge clk_i);
		converter_channel_select_i <= 4'hb;
		#1 chk("bg1", 8'(bandgap_route_on_o), 8'h01);
		foreach (ad[i])
		begin
			wr(ad[i], 8'hff);
			rd(ad[i], mk[i]);
		end
		chk("p2hb", 8'(p2_half_bias_o), 8'h03);
		chk("p13hb", p1_half_bias_o & p3_half_bias_o, 8'hff);
		// Mid-run reset must restore the P0 drive, P0 half-bias, LED and aux registers
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk("oe_rst", p0_pin_oe_o, 8'h00);
		chk("hb_rst", p0_half_bias_o, 8'h00);
		chk("bg_rst", 8'(bandgap_route_on_o), 8'h00);
		rd(8'hb1, 8'h04);
		rd(8'hf7, 8'h06);
		results();
	end
endmodule

// File: rtl/p0pfc_pkg.sv
/*
 Package for the Port0 pin function control block: SFR addresses, field
 positions and reset values. Assumes an 8-bit SFR space on the system clock.
*/
package p0pfc_pkg;
	localparam logic [7:0] ADDR_P0_DATA    = 8'h80;
	localparam logic [7:0] ADDR_P0_DRV     = 8'h91;
	localparam logic [7:0] ADDR_P0_HB      = 8'h92;
	localparam logic [7:0] ADDR_P0_AIN     = 8'haf;
	localparam logic [7:0] ADDR_LED_CTL    = 8'hb1;
	localparam logic [7:0] ADDR_SER_CTL    = 8'hbc;
	localparam logic [7:0] ADDR_P1_HB      = 8'hd1;
	localparam logic [7:0] ADDR_P2_HB      = 8'hd2;
	localparam logic [7:0] ADDR_P3_HB      = 8'hd3;
	localparam logic [7:0] ADDR_AUX_TWO    = 8'hf7;
	localparam logic [7:0] RST_P0_DATA     = 8'h00;
	localparam logic [7:0] RST_P0_DRV      = 8'h00;
	localparam logic [7:0] RST_HB          = 8'h00;
	localparam logic [7:0] RST_P0_AIN      = 8'h00;
	localparam logic [7:0] RST_LED_CTL     = 8'h04;
	localparam logic [7:0] RST_SER_CTL     = 8'h00;
	localparam logic [7:0] RST_AUX_TWO     = 8'h06;
	localparam logic [7:0] MASK_P0_AIN     = 8'hf0;
	localparam logic [7:0] MASK_P2_HB      = 8'h03;
	localparam logic [7:0] MASK_AUX_TWO    = 8'hf7;
	localparam int         LED_DUTY_POS    = 6;
	localparam int         AIN_POS         = 4;
	localparam int         SER_ON_POS      = 7;
	localparam int         SEL_OFF_POS     = 3;
	localparam int         BG_ROUTE_POS    = 4;
	localparam logic [3:0] BG_CHANNEL      = 4'hb;
	typedef enum logic [1:0] {
		P0PFC_LED_OFF,
		P0PFC_LED_DUTY8,
		P0PFC_LED_DUTY9,
		P0PFC_LED_DUTY10
	} p0pfc_led_t;
endpackage

// File: rtl/p0pfc_regfile.sv
/*
 Register store: one 8-bit SFR with write mask and reset value.
 Assumes write strobes from the SFR decoder on the same clock.
*/
`timescale 1ns/1ps
module p0pfc_regfile
	import p0pfc_pkg::*;
#(
	parameter logic [7:0] RST  = 8'h00,
	parameter logic [7:0] MASK = 8'hff
)(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Write port
	input  wire logic       we_i,
	input  wire logic [7:0] wdata_i,
	// Stored value
	output logic      [7:0] q_o
);
	typedef struct packed {
		logic [7:0] val;
	} p0pfc_reg_t;

	p0pfc_reg_t st_ff;
	p0pfc_reg_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		if (we_i)
		begin
			nxt_st.val = wdata_i & MASK;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_ff.val <= RST & MASK;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign q_o = st_ff.val;
endmodule

// File: rtl/p0pfc_top.sv
/*
 Port0 pin function control: SFRs for Port0 drive, pull-up, LCD half-bias
 and ADC override, plus LED, SPI pin and bandgap routing selects.
 Assumes an SFR bus with address, write and read strobes on clk_i.
*/
`timescale 1ns/1ps
module p0pfc_top
	import p0pfc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// SFR bus
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_we_i,
	input  wire logic       sfr_re_i,
	input  wire logic [7:0] sfr_wdata_i,
	output logic      [7:0] sfr_rdata_o,
	output logic            sfr_hit_o,
	// Port0 pins
	input  wire logic [7:0] p0_pin_i,
	output logic      [7:0] p0_pin_o,
	output logic      [7:0] p0_pin_oe_o,
	output logic      [7:0] p0_pullup_o,
	output logic      [7:0] p0_din_en_o,
	output logic      [7:0] p0_half_bias_o,
	output logic      [7:0] p0_analog_o,
	output logic      [7:0] p0_in_sync_o,
	// Other port half-bias enables
	output logic      [7:0] p1_half_bias_o,
	output logic      [1:0] p2_half_bias_o,
	output logic      [7:0] p3_half_bias_o,
	// LED, SPI and bandgap routing
	output logic      [1:0] led_duty_select_o,
	output logic            led_pins_auto_o,
	output logic      [3:0] led_seg_count_o,
	output logic            serial_port_on_o,
	output logic            spi_select_pin_o,
	input  wire logic [3:0] converter_channel_select_i,
	output logic            bandgap_route_on_o
);
	localparam int NREG = 10;

	// Slot of each register in the tables below
	localparam int IDX_P0_DATA = 0;
	localparam int IDX_P0_DRV  = 1;
	localparam int IDX_P0_HB   = 2;
	localparam int IDX_P0_AIN  = 3;
	localparam int IDX_LED_CTL = 4;
	localparam int IDX_SER_CTL = 5;
	localparam int IDX_P1_HB   = 6;
	localparam int IDX_P2_HB   = 7;
	localparam int IDX_P3_HB   = 8;
	localparam int IDX_AUX_TWO = 9;

	localparam logic [7:0] ADDRS [NREG] = '{
		ADDR_P0_DATA,
		ADDR_P0_DRV,
		ADDR_P0_HB,
		ADDR_P0_AIN,
		ADDR_LED_CTL,
		ADDR_SER_CTL,
		ADDR_P1_HB,
		ADDR_P2_HB,
		ADDR_P3_HB,
		ADDR_AUX_TWO
	};
	localparam logic [7:0] RSTS [NREG] = '{
		RST_P0_DATA,
		RST_P0_DRV,
		RST_HB,
		RST_P0_AIN,
		RST_LED_CTL,
		RST_SER_CTL,
		RST_HB,
		RST_HB,
		RST_HB,
		RST_AUX_TWO
	};
	// Reserved bits are cleared on write so they always read as zero
	localparam logic [7:0] MASKS [NREG] = '{
		8'hff,
		8'hff,
		8'hff,
		MASK_P0_AIN,
		8'hff,
		8'hff,
		8'hff,
		MASK_P2_HB,
		8'hff,
		MASK_AUX_TWO
	};

	// Address match used by write and read paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync3;
		logic [7:0] stable;
		logic [7:0] rdata;
	} p0pfc_st_t;

	p0pfc_st_t  st_ff;
	p0pfc_st_t  nxt_st;
	logic [7:0] regs [NREG];
	logic [7:0] r_p0_data;
	logic [7:0] r_drv;
	logic [7:0] r_hb;
	logic [7:0] r_ain;
	logic [7:0] r_led;
	logic [7:0] r_ser;
	logic [7:0] r_p1_hb;
	logic [7:0] r_p2_hb;
	logic [7:0] r_p3_hb;
	logic [7:0] r_aux_two;
	logic [7:0] ovr;
	logic [7:0] ain_map;
	logic [7:0] rd_mux;
	logic       any_hit;
	logic [NREG-1:0] wr_sel;

	////////////////////////////////////////////////////////////////////////
	// Write decode and register store

	always_comb
	begin
		for (int i = 0; i < NREG; i++)
		begin
			wr_sel[i] = sfr_we_i && hit(sfr_addr_i, ADDRS[i]);
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++)
		begin : g_reg
			p0pfc_regfile #(
				.RST  (RSTS[gi]),
				.MASK (MASKS[gi])
			) u_reg (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.we_i    (wr_sel[gi]),
				.wdata_i (sfr_wdata_i),
				.q_o     (regs[gi])
			);
		end
	endgenerate

	assign r_p0_data = regs[IDX_P0_DATA];
	assign r_drv     = regs[IDX_P0_DRV];
	assign r_hb      = regs[IDX_P0_HB];
	assign r_ain     = regs[IDX_P0_AIN];
	assign r_led     = regs[IDX_LED_CTL];
	assign r_ser     = regs[IDX_SER_CTL];
	assign r_p1_hb   = regs[IDX_P1_HB];
	assign r_p2_hb   = regs[IDX_P2_HB];
	assign r_p3_hb   = regs[IDX_P3_HB];
	assign r_aux_two = regs[IDX_AUX_TWO];

	////////////////////////////////////////////////////////////////////////
	// Read path and input synchroniser

	always_comb
	begin
		rd_mux  = 8'h00;
		any_hit = 1'b0;
		for (int i = 0; i < NREG; i++)
		begin
			if (hit(sfr_addr_i, ADDRS[i]))
			begin
				rd_mux  = regs[i];
				any_hit = 1'b1;
			end
		end
	end

	always_comb
	begin
		nxt_st       = st_ff;
		nxt_st.sync1 = p0_pin_i;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.sync3 = st_ff.sync2;
		for (int i = 0; i < 8; i++)
		begin
			if (st_ff.sync2[i] == st_ff.sync3[i])
			begin
				nxt_st.stable[i] = st_ff.sync3[i];
			end
		end
		if (sfr_re_i)
		begin
			nxt_st.rdata = rd_mux;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign sfr_rdata_o  = st_ff.rdata;
	assign sfr_hit_o    = any_hit;
	assign p0_in_sync_o = st_ff.stable;

	////////////////////////////////////////////////////////////////////////
	// Port0 pin control

	assign ain_map = {r_ain[7:AIN_POS], 4'h0};
	assign ovr     = r_hb | ain_map;

	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_pin
			assign p0_pin_oe_o[gi] = r_drv[gi] && !ovr[gi];
			assign p0_pin_o[gi]    = p0_pin_oe_o[gi] && r_p0_data[gi];
			assign p0_pullup_o[gi] = !r_drv[gi] && r_p0_data[gi]
				&& !ovr[gi];
			assign p0_din_en_o[gi] = !r_drv[gi] && !ovr[gi];
		end
	endgenerate

	assign p0_half_bias_o = r_hb;
	assign p0_analog_o    = ain_map;
	assign p1_half_bias_o = r_p1_hb;
	assign p2_half_bias_o = r_p2_hb[1:0];
	assign p3_half_bias_o = r_p3_hb;

	////////////////////////////////////////////////////////////////////////
	// LED, SPI and bandgap selects

	p0pfc_led_t led_mode;
	assign led_mode = p0pfc_led_t'(r_led[LED_DUTY_POS +: 2]);
	assign led_duty_select_o = r_led[LED_DUTY_POS +: 2];

	always_comb
	begin
		led_pins_auto_o = 1'b1;
		led_seg_count_o = 4'h0;
		unique case (led_mode)
			P0PFC_LED_OFF:
			begin
				led_pins_auto_o = 1'b0;
			end
			P0PFC_LED_DUTY8:
			begin
				led_seg_count_o = 4'h4;
			end
			P0PFC_LED_DUTY9:
			begin
				led_seg_count_o = 4'h5;
			end
			P0PFC_LED_DUTY10:
			begin
				led_seg_count_o = 4'h6;
			end
		endcase
	end

	assign serial_port_on_o   = r_ser[SER_ON_POS];
	assign spi_select_pin_o   = r_ser[SER_ON_POS]
		&& !r_ser[SEL_OFF_POS];
	assign bandgap_route_on_o = r_aux_two[BG_ROUTE_POS]
		&& (converter_channel_select_i == BG_CHANNEL);
endmodule
